// *** core/dsdec_decoder.sv ***
// top: program and data space decoder with stack pointer and paged registers
//
// Summary of operation
// - flash from zero, 32k or 16k top
// - lock byte location; above it reserved
// - code reads flash; xdata write retargetable
// - 256 internal plus 2048 expansion bytes
// - lower 128 bytes direct and indirect
// - above 0x7F: direct registers, indirect RAM
// - four banks of eight, status bits select
// - bytes 0x20-0x2F map to 128 bits
// - bit versus byte from operand type
// - push writes pointer plus one, increments
// - reset pointer to 0x07
// - direct 0x80-0xFF goes to registers
// - addresses ending 0 or 8 bit-addressable
// - 256 pages, three populated
// - interrupt entry pushes page stack
// - interrupt return pops, bottom reads zero
// - software stack writes never push/pop
// - entry page zero, network irq 0x0C
// - autopaging enable bit, reset enabled
// - all-page registers ignore page select
// - bank bits map to byte ranges
`timescale 1ns/100ps
module dsdec_decoder (
   input  wire logic                 sys_clk,
   input  wire logic                 rst,
   input  wire logic                 flash_32k_mode,
   input  wire logic                 xdata_to_flash,
   input  wire logic                 bank_select_low,
   input  wire logic                 bank_select_high,
   input  wire logic                 req_valid,
   input  wire dsdec_pkg::dsdec_kind_t req_kind,
   input  wire logic                 req_indirect,
   input  wire logic                 req_write,
   input  wire logic [15:0]          req_addr,
   input  wire logic [7:0]           req_wdata,
   input  wire logic                 irq_entry,
   input  wire logic                 area_network_controller_irq,
   input  wire logic                 interrupt_return,
   output logic                      rsp_valid,
   output logic                      flash_sel,
   output logic                      flash_write,
   output logic                      lock_byte_hit,
   output logic                      reserved_hit,
   output logic [15:0]               flash_addr,
   output logic                      expansion_ram_sel,
   output logic [10:0]               expansion_ram_addr,
   output logic                      iram_sel,
   output logic [7:0]                iram_addr,
   output logic                      sfr_sel,
   output logic [7:0]                sfr_addr,
   output logic [7:0]                sfr_page,
   output logic                      sfr_page_populated,
   output logic                      bit_access,
   output logic [2:0]                bit_index,
   output logic                      mem_write,
   output logic [7:0]                mem_wdata,
   output logic                      local_hit,
   output logic [7:0]                local_rdata,
   output logic [7:0]                stack_pointer,
   output logic [7:0]                page_select_reg,
   output logic [7:0]                page_stack_middle,
   output logic [7:0]                page_stack_bottom,
   output logic [7:0]                page_control_reg
);
   typedef struct packed {
      logic        sp;
      logic [7:0]  sp_val;
      logic        rsp;
      logic        fsel;
      logic        fwr;
      logic        lock;
      logic        rsvd;
      logic [15:0] faddr;
      logic        xsel;
      logic [10:0] xaddr;
      logic        isel;
      logic [7:0]  iaddr;
      logic        ssel;
      logic [7:0]  saddr;
      logic [7:0]  spage;
      logic        spop;
      logic        bit_acc;
      logic [2:0]  bidx;
      logic        wr;
      logic [7:0]  wdata;
      logic        lhit;
      logic [7:0]  lrdata;
   } dsdec_state_t;

   dsdec_state_t q_reg;
   dsdec_state_t q_next;

   logic [1:0]  bank;
   logic        direct_sfr;
   logic [7:0]  byte_addr;
   logic        page_wr_en;
   logic [1:0]  page_wr_sel;
   logic        sp_wr_en;
   logic [15:0] flash_end;
   logic [15:0] lock_addr;

   // registers that answer whatever page is selected
   function automatic logic all_pages(input logic [7:0] a);
      all_pages = (a == dsdec_pkg::ADDR_PORT0) || (a == dsdec_pkg::ADDR_PORT1)
               || (a == dsdec_pkg::ADDR_PORT2) || (a == dsdec_pkg::ADDR_PORT3)
               || (a == dsdec_pkg::ADDR_SP) || (a == dsdec_pkg::ADDR_PAGE_SEL)
               || (a == dsdec_pkg::ADDR_STATUS) || (a == dsdec_pkg::ADDR_ACCUM)
               || (a == dsdec_pkg::ADDR_SECOND_ACC);
   endfunction

   // a register address matches when on all pages or when the config page is selected
   function automatic logic page_match(input logic [7:0] a, input logic [7:0] want, input logic [7:0] page);
      page_match = (all_pages(a) || page == dsdec_pkg::PAGE_CONFIG) && (a == want);
   endfunction

   function automatic logic populated(input logic [7:0] p);
      populated = (p == dsdec_pkg::PAGE_DEFAULT) || (p == dsdec_pkg::PAGE_CAN) || (p == dsdec_pkg::PAGE_CONFIG);
   endfunction

   assign bank       = {bank_select_high, bank_select_low};
   assign byte_addr  = req_addr[7:0];
   assign direct_sfr = byte_addr[7] && !req_indirect;
   assign flash_end  = flash_32k_mode ? dsdec_pkg::FLASH_END_32K : dsdec_pkg::FLASH_END_16K;
   assign lock_addr  = flash_32k_mode ? dsdec_pkg::LOCK_BYTE_32K : dsdec_pkg::LOCK_BYTE_16K;

   // software byte writes into the locally held registers
   always_comb begin
      page_wr_en  = 1'b0;
      page_wr_sel = dsdec_pkg::SEL_PAGE;
      sp_wr_en    = 1'b0;
      if (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BYTE && req_write && direct_sfr) begin
         if (page_match(byte_addr, dsdec_pkg::ADDR_SP, page_select_reg)) begin
            sp_wr_en = 1'b1;
         end else if (page_match(byte_addr, dsdec_pkg::ADDR_PAGE_SEL, page_select_reg)) begin
            page_wr_en = 1'b1;
         end else if (page_match(byte_addr, dsdec_pkg::ADDR_PAGE_MID, page_select_reg)) begin
            page_wr_en  = 1'b1;
            page_wr_sel = dsdec_pkg::SEL_MID;
         end else if (page_match(byte_addr, dsdec_pkg::ADDR_PAGE_BOT, page_select_reg)) begin
            page_wr_en  = 1'b1;
            page_wr_sel = dsdec_pkg::SEL_BOT;
         end else if (page_match(byte_addr, dsdec_pkg::ADDR_PAGE_CTRL, page_select_reg)) begin
            page_wr_en  = 1'b1;
            page_wr_sel = dsdec_pkg::SEL_CTRL;
         end
      end
   end

   always_comb begin
      q_next         = q_reg;
      q_next.rsp     = 1'b0;
      q_next.fsel    = 1'b0;
      q_next.fwr     = 1'b0;
      q_next.lock    = 1'b0;
      q_next.rsvd    = 1'b0;
      q_next.xsel    = 1'b0;
      q_next.isel    = 1'b0;
      q_next.ssel    = 1'b0;
      q_next.bit_acc = 1'b0;
      q_next.wr      = 1'b0;
      q_next.lhit    = 1'b0;
      q_next.spop    = populated(page_select_reg);
      if (req_valid) begin
         q_next.rsp   = 1'b1;
         // write data holds until the next request, not the idle bus value
         q_next.wdata = req_wdata;
         case (req_kind)
            dsdec_pkg::DSDEC_CODE_READ, dsdec_pkg::DSDEC_XDATA_WRITE: begin
               // code reads hit flash unless reserved; xdata writes only when retargeted
               if (req_kind == dsdec_pkg::DSDEC_CODE_READ || xdata_to_flash) begin
                  q_next.faddr = req_addr;
                  q_next.fwr   = (req_kind == dsdec_pkg::DSDEC_XDATA_WRITE);
                  q_next.lock  = (req_addr == lock_addr);
                  q_next.rsvd  = (req_addr > flash_end) || (flash_32k_mode && req_addr > lock_addr);
                  q_next.fsel  = !q_next.rsvd;
               end else begin
                  q_next.xaddr = req_addr[10:0];
                  q_next.wr    = 1'b1;
                  q_next.rsvd  = (req_addr > dsdec_pkg::EXPANSION_RAM_LAST);
                  q_next.xsel  = !q_next.rsvd;
               end
            end
            dsdec_pkg::DSDEC_XDATA_READ: begin
               q_next.xaddr = req_addr[10:0];
               q_next.rsvd  = (req_addr > dsdec_pkg::EXPANSION_RAM_LAST);
               q_next.xsel  = !q_next.rsvd;
            end
            dsdec_pkg::DSDEC_DATA_BYTE: begin
               q_next.wr = req_write;
               if (direct_sfr) begin
                  // unoccupied addresses are passed on unchecked
                  q_next.ssel  = 1'b1;
                  q_next.saddr = byte_addr;
                  q_next.spage = all_pages(byte_addr) ? dsdec_pkg::PAGE_DEFAULT : page_select_reg;
                  q_next.lhit  = page_match(byte_addr, dsdec_pkg::ADDR_SP, page_select_reg)
                              || page_match(byte_addr, dsdec_pkg::ADDR_PAGE_SEL, page_select_reg)
                              || page_match(byte_addr, dsdec_pkg::ADDR_PAGE_MID, page_select_reg)
                              || page_match(byte_addr, dsdec_pkg::ADDR_PAGE_BOT, page_select_reg)
                              || page_match(byte_addr, dsdec_pkg::ADDR_PAGE_CTRL, page_select_reg);
                  case (1'b1)
                     (byte_addr == dsdec_pkg::ADDR_SP): q_next.lrdata = q_reg.sp_val;
                     (byte_addr == dsdec_pkg::ADDR_PAGE_SEL): q_next.lrdata = page_select_reg;
                     (byte_addr == dsdec_pkg::ADDR_PAGE_MID): q_next.lrdata = page_stack_middle;
                     (byte_addr == dsdec_pkg::ADDR_PAGE_BOT): q_next.lrdata = page_stack_bottom;
                     default: q_next.lrdata = page_control_reg;
                  endcase
               end else begin
                  q_next.isel  = 1'b1;
                  q_next.iaddr = byte_addr;
               end
            end
            dsdec_pkg::DSDEC_DATA_BIT: begin
               // operand type alone makes this a bit access
               q_next.bit_acc = 1'b1;
               q_next.wr      = req_write;
               q_next.bidx    = byte_addr[2:0];
               if (byte_addr <= dsdec_pkg::LOWER_RAM_TOP) begin
                  q_next.isel  = 1'b1;
                  q_next.iaddr = dsdec_pkg::BIT_BYTE_BASE + {4'h0, byte_addr[6:3]};
               end else begin
                  // only bytes ending in 0 or 8 carry bit addresses
                  q_next.ssel  = 1'b1;
                  q_next.saddr = {byte_addr[7:3], 3'h0};
                  q_next.spage = all_pages(q_next.saddr) ? dsdec_pkg::PAGE_DEFAULT : page_select_reg;
               end
            end
            dsdec_pkg::DSDEC_BANK_REG: begin
               q_next.wr    = req_write;
               q_next.isel  = 1'b1;
               q_next.iaddr = {3'h0, bank, byte_addr[2:0]};
            end
            dsdec_pkg::DSDEC_PUSH: begin
               q_next.wr     = 1'b1;
               q_next.isel   = 1'b1;
               q_next.iaddr  = q_reg.sp_val + 8'h01;
               q_next.sp_val = q_reg.sp_val + 8'h01;
            end
            dsdec_pkg::DSDEC_POP: begin
               q_next.isel   = 1'b1;
               q_next.iaddr  = q_reg.sp_val;
               q_next.sp_val = q_reg.sp_val - 8'h01;
            end
            default: q_next.rsp = 1'b0;
         endcase
      end
      if (sp_wr_en) begin
         q_next.sp_val = req_wdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_reg        <= '0;
         q_reg.sp_val <= dsdec_pkg::SP_RESET;
      end else begin
         q_reg <= q_next;
      end
   end

   dsdec_page_stack u_page_stack (
      .sys_clk                     (sys_clk),
      .rst                         (rst),
      .irq_entry                   (irq_entry),
      .area_network_controller_irq (area_network_controller_irq),
      .interrupt_return            (interrupt_return),
      .wr_en                       (page_wr_en),
      .wr_sel                      (page_wr_sel),
      .wr_data                     (req_wdata),
      .page_select_reg             (page_select_reg),
      .page_stack_middle           (page_stack_middle),
      .page_stack_bottom           (page_stack_bottom),
      .page_control_reg            (page_control_reg)
   );

   assign rsp_valid          = q_reg.rsp;
   assign flash_sel          = q_reg.fsel;
   assign flash_write        = q_reg.fwr;
   assign lock_byte_hit      = q_reg.lock;
   assign reserved_hit       = q_reg.rsvd;
   assign flash_addr         = q_reg.faddr;
   assign expansion_ram_sel           = q_reg.xsel;
   assign expansion_ram_addr          = q_reg.xaddr;
   assign iram_sel           = q_reg.isel;
   assign iram_addr          = q_reg.iaddr;
   assign sfr_sel            = q_reg.ssel;
   assign sfr_addr           = q_reg.saddr;
   assign sfr_page           = q_reg.spage;
   assign sfr_page_populated = q_reg.spop;
   assign bit_access         = q_reg.bit_acc;
   assign bit_index          = q_reg.bidx;
   assign mem_write          = q_reg.wr;
   assign mem_wdata          = q_reg.wdata;
   assign local_hit          = q_reg.lhit;
   assign local_rdata        = q_reg.lrdata;
   assign stack_pointer      = q_reg.sp_val;

   default clocking dsdec_cb @(posedge sys_clk); endclocking

   logic req_push;
   logic req_pop;
   assign req_push = req_valid && req_kind == dsdec_pkg::DSDEC_PUSH;
   assign req_pop  = req_valid && req_kind == dsdec_pkg::DSDEC_POP;

   a_push_slot: assert property (disable iff (rst)
      req_push |=> iram_sel && mem_write && iram_addr == 8'($past(stack_pointer) + 8'h01)
         && stack_pointer == iram_addr)
      else $error("push slot wrong");
   a_pop_slot: assert property (disable iff (rst)
      req_pop |=> iram_sel && !mem_write && iram_addr == $past(stack_pointer)
         && stack_pointer == 8'($past(stack_pointer) - 8'h01))
      else $error("pop slot wrong");
   a_sp_reset: assert property (rst |=> stack_pointer == 8'h07)
      else $error("stack pointer reset wrong");
   a_direct_upper: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BYTE && !req_indirect && req_addr[7])
         |=> sfr_sel && !iram_sel && sfr_addr == $past(req_addr[7:0]))
      else $error("direct upper not routed to registers");
   a_indirect_upper: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BYTE && req_indirect)
         |=> iram_sel && !sfr_sel && iram_addr == $past(req_addr[7:0]))
      else $error("indirect not routed to ram");
   a_lower_direct: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BYTE && !req_addr[7]) |=> iram_sel)
      else $error("lower ram not reached");
   a_bank_map: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_BANK_REG)
         |=> iram_addr == {3'h0, $past(bank_select_high), $past(bank_select_low), $past(req_addr[2:0])})
      else $error("bank register address wrong");
   a_bit_map: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BIT && !req_addr[7])
         |=> bit_access && iram_addr == 8'(8'h20 + $past(req_addr[6:3])) && bit_index == $past(req_addr[2:0]))
      else $error("bit map wrong");
   a_code_flash: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_CODE_READ && req_addr <= 16'h3FFF)
         |=> flash_sel && !flash_write && !expansion_ram_sel)
      else $error("code read missed flash");
   a_lock_byte: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_CODE_READ && flash_32k_mode && req_addr == 16'h7BFF)
         |=> lock_byte_hit && flash_sel)
      else $error("lock byte missed");
   a_page_all: assert property (disable iff (rst)
      (req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BYTE && !req_indirect && req_addr[7:0] == 8'h80)
         |=> sfr_page == 8'h00)
      else $error("all-page register paged");

   c_push_pop: cover property (disable iff (rst) req_push ##1 req_pop);
   c_flash_write: cover property (disable iff (rst) req_valid && req_kind == dsdec_pkg::DSDEC_XDATA_WRITE
      && xdata_to_flash);
   c_bit_sfr: cover property (disable iff (rst) req_valid && req_kind == dsdec_pkg::DSDEC_DATA_BIT && req_addr[7]);
endmodule

// *** core/dsdec_page_stack.sv ***
// three-byte register page stack with automatic paging control
`timescale 1ns/100ps
module dsdec_page_stack (
   input  wire logic       sys_clk,
   input  wire logic       rst,
   input  wire logic       irq_entry,
   input  wire logic       area_network_controller_irq,
   input  wire logic       interrupt_return,
   input  wire logic       wr_en,
   input  wire logic [1:0] wr_sel,
   input  wire logic [7:0] wr_data,
   output logic      [7:0] page_select_reg,
   output logic      [7:0] page_stack_middle,
   output logic      [7:0] page_stack_bottom,
   output logic      [7:0] page_control_reg
);
   typedef struct packed {
      logic [7:0] page;
      logic [7:0] mid;
      logic [7:0] bot;
      logic       en;
   } dsdec_stack_t;

   dsdec_stack_t q_reg;
   dsdec_stack_t q_next;
   logic         auto_on;

   assign auto_on = q_reg.en;

   always_comb begin
      q_next = q_reg;
      if (wr_en) begin
         case (wr_sel)
            dsdec_pkg::SEL_PAGE: q_next.page = wr_data;
            dsdec_pkg::SEL_MID: q_next.mid = wr_data;
            dsdec_pkg::SEL_BOT: q_next.bot = wr_data;
            default: q_next.en = wr_data[dsdec_pkg::PAGE_EN_BIT];
         endcase
      end
      // hardware movement wins over a software write in the same cycle
      if (auto_on && irq_entry) begin
         q_next.bot  = q_reg.mid;
         q_next.mid  = q_reg.page;
         q_next.page = area_network_controller_irq ? dsdec_pkg::PAGE_CAN : dsdec_pkg::PAGE_DEFAULT;
      end else if (auto_on && interrupt_return) begin
         q_next.page = q_reg.mid;
         q_next.mid  = q_reg.bot;
         q_next.bot  = dsdec_pkg::PAGE_DEFAULT;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         q_reg.page <= dsdec_pkg::PAGE_DEFAULT;
         q_reg.mid  <= dsdec_pkg::PAGE_DEFAULT;
         q_reg.bot  <= dsdec_pkg::PAGE_DEFAULT;
         q_reg.en   <= dsdec_pkg::PAGE_CTRL_RESET[dsdec_pkg::PAGE_EN_BIT];
      end else begin
         q_reg <= q_next;
      end
   end

   assign page_select_reg   = q_reg.page;
   assign page_stack_middle = q_reg.mid;
   assign page_stack_bottom = q_reg.bot;
   assign page_control_reg  = {7'h00, q_reg.en};

   default clocking dsdec_stk_cb @(posedge sys_clk); endclocking

   a_entry_push: assert property (disable iff (rst)
      (irq_entry && auto_on) |=> (page_stack_middle == $past(page_select_reg))
         && (page_stack_bottom == $past(page_stack_middle)))
      else $error("page stack push wrong");
   a_entry_page: assert property (disable iff (rst)
      (irq_entry && auto_on) |=> page_select_reg == ($past(area_network_controller_irq) ? 8'h0C : 8'h00))
      else $error("interrupt page wrong");
   a_return_pop: assert property (disable iff (rst)
      (interrupt_return && !irq_entry && auto_on) |=> (page_select_reg == $past(page_stack_middle))
         && (page_stack_middle == $past(page_stack_bottom)) && (page_stack_bottom == 8'h00))
      else $error("page stack pop wrong");
   a_write_no_move: assert property (disable iff (rst)
      (wr_en && wr_sel != 2'h0 && !irq_entry && !interrupt_return) |=> $stable(page_select_reg))
      else $error("stack write moved page");
   a_auto_off: assert property (disable iff (rst)
      (!auto_on && !wr_en) |=> $stable(page_select_reg) && $stable(page_stack_middle))
      else $error("stack moved while disabled");
   c_can_entry: cover property (disable iff (rst) irq_entry && auto_on && area_network_controller_irq);
   c_nested: cover property (disable iff (rst) (irq_entry && auto_on) ##[1:20] (irq_entry && auto_on));
endmodule

// *** core/dsdec_pkg.sv ***
// package: constants and access kinds for the data space decoder
package dsdec_pkg;

   typedef enum logic [2:0] {
      DSDEC_CODE_READ,
      DSDEC_XDATA_READ,
      DSDEC_XDATA_WRITE,
      DSDEC_DATA_BYTE,
      DSDEC_DATA_BIT,
      DSDEC_BANK_REG,
      DSDEC_PUSH,
      DSDEC_POP
   } dsdec_kind_t;

   // program space
   localparam logic [15:0] FLASH_END_32K   = 16'h7FFF;
   localparam logic [15:0] FLASH_END_16K   = 16'h3FFF;
   localparam logic [15:0] LOCK_BYTE_32K   = 16'h7BFF;
   localparam logic [15:0] LOCK_BYTE_16K   = 16'h3FFF;
   // data space
   localparam logic [15:0] EXPANSION_RAM_LAST       = 16'h07FF;
   localparam logic [7:0]  LOWER_RAM_TOP   = 8'h7F;
   localparam logic [7:0]  BIT_BYTE_BASE   = 8'h20;
   localparam logic [7:0]  SP_RESET        = 8'h07;
   // register space pages
   localparam logic [7:0]  PAGE_DEFAULT    = 8'h00;
   localparam logic [7:0]  PAGE_CAN        = 8'h0C;
   localparam logic [7:0]  PAGE_CONFIG     = 8'h0F;
   localparam logic [7:0]  PAGE_CTRL_RESET = 8'h01;
   localparam int          PAGE_EN_BIT     = 0;
   // register addresses kept in this block
   localparam logic [7:0]  ADDR_SP         = 8'h81;
   localparam logic [7:0]  ADDR_PAGE_CTRL  = 8'h84;
   localparam logic [7:0]  ADDR_PAGE_MID   = 8'h85;
   localparam logic [7:0]  ADDR_PAGE_BOT   = 8'h86;
   localparam logic [7:0]  ADDR_PAGE_SEL   = 8'hA7;
   // registers present on every page
   localparam logic [7:0]  ADDR_PORT0      = 8'h80;
   localparam logic [7:0]  ADDR_PORT1      = 8'h90;
   localparam logic [7:0]  ADDR_PORT2      = 8'hA0;
   localparam logic [7:0]  ADDR_PORT3      = 8'hB0;
   localparam logic [7:0]  ADDR_STATUS     = 8'hD0;
   localparam logic [7:0]  ADDR_ACCUM      = 8'hE0;
   localparam logic [7:0]  ADDR_SECOND_ACC = 8'hF0;
   // page stack write selects
   localparam logic [1:0]  SEL_PAGE        = 2'h0;
   localparam logic [1:0]  SEL_MID         = 2'h1;
   localparam logic [1:0]  SEL_BOT         = 2'h2;
   localparam logic [1:0]  SEL_CTRL        = 2'h3;

endpackage

// *** tb/data_space_decode_sfr_paging_test.sv ***
// self-checking bench for the data space decoder
`timescale 1ns/100ps
module data_space_decode_sfr_paging_test;
   logic sys_clk = 1'h0;
   logic rst, flash_32k_mode, xdata_to_flash, bank_select_low, bank_select_high, req_valid, req_indirect, req_write;
   logic irq_entry, area_network_controller_irq, interrupt_return, rsp_valid, flash_sel, flash_write;
   logic lock_byte_hit, reserved_hit, expansion_ram_sel, iram_sel, sfr_sel, sfr_page_populated, bit_access, mem_write, local_hit;
   dsdec_pkg::dsdec_kind_t req_kind;
   logic [15:0] req_addr, flash_addr;
   logic [10:0] expansion_ram_addr;
   logic [7:0]  req_wdata, iram_addr, sfr_addr, sfr_page, mem_wdata, local_rdata, stack_pointer;
   logic [7:0]  page_select_reg, page_stack_middle, page_stack_bottom, page_control_reg;
   logic [2:0]  bit_index;
   int          errors = 0;
   int          n_checks = 0;
   always #5 sys_clk = ~sys_clk;
   dsdec_core_model core_u (.sys_clk, .req_kind, .req_valid, .req_indirect, .req_write, .req_addr, .req_wdata,
      .irq_entry, .area_network_controller_irq, .interrupt_return);
   dsdec_decoder dut_u (.sys_clk, .rst, .flash_32k_mode, .xdata_to_flash, .bank_select_low, .bank_select_high,
      .req_valid, .req_kind, .req_indirect, .req_write, .req_addr, .req_wdata, .irq_entry,
      .area_network_controller_irq, .interrupt_return, .rsp_valid, .flash_sel, .flash_write, .lock_byte_hit,
      .reserved_hit, .flash_addr, .expansion_ram_sel, .expansion_ram_addr, .iram_sel, .iram_addr, .sfr_sel, .sfr_addr, .sfr_page,
      .sfr_page_populated, .bit_access, .bit_index, .mem_write, .mem_wdata, .local_hit, .local_rdata,
      .stack_pointer, .page_select_reg, .page_stack_middle, .page_stack_bottom, .page_control_reg);
   task automatic check(input string nm, input logic [23:0] seen, exp);
      n_checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d errors %0d", n_checks, errors);
      if (errors == 0 && n_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (2000) @(posedge sys_clk);
      errors++;
      end_of_test();
   end
   initial begin
      {rst, flash_32k_mode, xdata_to_flash, bank_select_high, bank_select_low} <= 5'h18;
      repeat (16) @(posedge sys_clk);
      rst <= 1'h0;
      #1 check("reset", {stack_pointer, page_select_reg, page_control_reg}, 24'h07_0001);
      core_u.access(dsdec_pkg::DSDEC_PUSH, 1'h0, 1'h0, 16'h0000, 8'hA5);
      #1 check("push", {iram_addr, mem_wdata, stack_pointer}, 24'h08_A508);
      core_u.access(dsdec_pkg::DSDEC_POP, 1'h0, 1'h0, 16'h0000, 8'h00);
      #1 check("pop", {mem_write, iram_addr, stack_pointer}, 24'h00_0807);
      for (int b = 0; b < 4; b++) begin
         {bank_select_high, bank_select_low} <= b[1:0];
         core_u.access(dsdec_pkg::DSDEC_BANK_REG, 1'h0, 1'h0, 16'h0003, 8'h00);
         #1 check("bank", iram_addr, 24'(b * 8 + 3));
      end
      core_u.access(dsdec_pkg::DSDEC_DATA_BIT, 1'h0, 1'h0, 16'h0013, 8'h00);
      #1 check("bit", {iram_addr, bit_access, bit_index}, 24'h00_022B);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h1, 1'h0, 16'h0090, 8'h00);
      #1 check("indirect", {iram_sel, sfr_sel}, 24'h00_0002);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h0, 1'h0, 16'h0090, 8'h00);
      #1 check("direct", {iram_sel, sfr_sel}, 24'h00_0001);
      core_u.access(dsdec_pkg::DSDEC_CODE_READ, 1'h0, 1'h0, 16'h7BFF, 8'h00);
      #1 check("lock", {flash_sel, lock_byte_hit, reserved_hit}, 24'h00_0006);
      core_u.access(dsdec_pkg::DSDEC_CODE_READ, 1'h0, 1'h0, 16'h7C00, 8'h00);
      #1 check("rsvd", {flash_sel, lock_byte_hit, reserved_hit}, 24'h00_0001);
      {flash_32k_mode, xdata_to_flash} <= 2'h1;
      core_u.access(dsdec_pkg::DSDEC_CODE_READ, 1'h0, 1'h0, 16'h4000, 8'h00);
      #1 check("16k", {flash_sel, reserved_hit}, 24'h00_0001);
      core_u.access(dsdec_pkg::DSDEC_XDATA_WRITE, 1'h0, 1'h1, 16'h0100, 8'h3C);
      #1 check("xflash", {flash_write, expansion_ram_sel, flash_addr}, 24'h02_0100);
      core_u.access(dsdec_pkg::DSDEC_XDATA_READ, 1'h0, 1'h0, 16'h07FF, 8'h00);
      #1 check("xread", {expansion_ram_sel, reserved_hit, expansion_ram_addr}, 24'h00_17FF);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h0, 1'h1, 16'h00A7, 8'h0F);
      core_u.pulse(1'h1, 1'h1, 1'h0);
      #1 check("can", {page_select_reg, page_stack_middle}, 24'h00_0C0F);
      core_u.pulse(1'h1, 1'h0, 1'h0);
      #1 check("entry", {page_select_reg, page_stack_middle, page_stack_bottom}, 24'h00_0C0F);
      core_u.pulse(1'h0, 1'h0, 1'h1);
      #1 check("return", {page_select_reg, page_stack_middle, page_stack_bottom}, 24'h0C_0F00);
      core_u.access(dsdec_pkg::DSDEC_DATA_BIT, 1'h0, 1'h0, 16'h0093, 8'h00);
      #1 check("bitsfr", {sfr_sel, sfr_addr, bit_index}, 24'h00_0C83);
      check("allpage", sfr_page, 24'h00_0000);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h0, 1'h0, 16'h00A7, 8'h00);
      #1 check("local", {rsp_valid, sfr_page_populated, local_hit, local_rdata}, 24'h00_070C);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h0, 1'h1, 16'h00A7, 8'h0F);
      core_u.access(dsdec_pkg::DSDEC_DATA_BYTE, 1'h0, 1'h1, 16'h0084, 8'h00);
      core_u.pulse(1'h1, 1'h1, 1'h0);
      #1 check("autooff", {page_control_reg, page_select_reg, page_stack_middle}, 24'h00_0F0F);
      end_of_test();
   end
endmodule

// *** tb/dsdec_core_model.sv ***
// core model: issues decoder requests and interrupt pulses
`timescale 1ns/100ps
module dsdec_core_model (
   input  wire logic             sys_clk,
   output dsdec_pkg::dsdec_kind_t req_kind,
   output logic                  req_valid,
   output logic                  req_indirect,
   output logic                  req_write,
   output logic [15:0]           req_addr,
   output logic [7:0]            req_wdata,
   output logic                  irq_entry,
   output logic                  area_network_controller_irq,
   output logic                  interrupt_return
);
   initial begin
      {req_valid, req_indirect, req_write, req_addr, req_wdata} = 27'h0;
      req_kind = dsdec_pkg::DSDEC_CODE_READ;
      {irq_entry, area_network_controller_irq, interrupt_return} = 3'h0;
   end
   // drives one request for one clock, any address, then releases it
   task automatic access(input dsdec_pkg::dsdec_kind_t k, input logic i, w, input logic [15:0] a,
                         input logic [7:0] d);
      @(posedge sys_clk);
      {req_valid, req_indirect, req_write, req_addr, req_wdata} <= {1'h1, i, w, a, d};
      req_kind <= k;
      @(posedge sys_clk);
      // released lines flip so stale data is never mistaken for held data
      {req_valid, req_addr, req_wdata} <= {1'h0, ~a, ~d};
   endtask
   task automatic pulse(input logic e, c, r);
      @(posedge sys_clk);
      {irq_entry, area_network_controller_irq, interrupt_return} <= {e, c, r};
      @(posedge sys_clk);
      {irq_entry, area_network_controller_irq, interrupt_return} <= 3'h0;
   endtask
endmodule
